// [logic/dsu_pkg.sv]
// Types of the synthesizer tone updater
`include "dsu_regs.svh"
package dsu_pkg;
	typedef struct packed {
		logic [`DSU_FREQ_W-1:0] freq;
		logic [`DSU_PHASE_W-1:0] phase;
	} dsu_tone_type;
	typedef dsu_tone_type [`DSU_CHIPS-1:0] dsu_tone_set_type;
	typedef logic [`DSU_WRITE_BITS-1:0] dsu_word_type;
	typedef enum logic [2:0] {
		L_RESET = 3'b000,
		L_SETUP = 3'b001,
		L_IDLE = 3'b010,
		L_SHIFT = 3'b011,
		L_UPDATE = 3'b100,
		L_ALIGN = 3'b101
	} dsu_link_state_type;
	typedef struct packed {
		dsu_tone_set_type [1:0] fifo;
		logic wrPtr;
		logic rdPtr;
		logic [1:0] count;
		logic toneReady;
		logic [7:0] tick;
		dsu_tone_set_type hold;
		logic haveTone;
		logic reqTog;
		logic ackSync1;
		logic ackSync2;
		logic setupSync1;
		logic setupSync2;
		logic setupDone;
		logic overrun;
	} dsu_ref_state_type;
	typedef struct packed {
		dsu_link_state_type state;
		logic [7:0] cnt;
		logic [7:0] halfCnt;
		logic [5:0] bitCnt;
		logic inSetup;
		logic sclk;
		logic csN;
		dsu_word_type [`DSU_CHIPS-1:0] shift;
		logic [`DSU_CHIPS-1:0] sdio;
		logic [`DSU_CHIPS-1:0] ioUpdate;
		logic [`DSU_CHIPS-1:0] ioReset;
		logic masterReset;
		logic reqSync1;
		logic reqSync2;
		logic reqSeen;
		logic ackTog;
		logic setupDone;
		logic syncIn1;
		logic syncIn2;
		logic [`DSU_CHIPS-1:0] alignOut;
	} dsu_link_state_type_s_type;
endpackage

// [logic/dsu_regs.svh]
// Constants of the synthesizer tone updater
`ifndef DSU_REGS_SVH
`define DSU_REGS_SVH
`define DSU_CHIPS 4
`define DSU_INSTR_W 8
`define DSU_FREQ_W 32
`define DSU_PHASE_W 16
`define DSU_WRITE_BITS 56
`define DSU_SETUP_BITS 40
`define DSU_PROFILE_INSTR 8'h0e
`define DSU_CTRL_INSTR 8'h00
`define DSU_CTRL_LSB_FIRST 32'h00010000
`define DSU_UPDATE_NS 1000
`define DSU_REF_CLK_MHZ 50
`define DSU_SER_RATE_KBPS 68000
`define DSU_LINK_CLK_KHZ 136000
`define DSU_RESET_CYCLES 16
`define DSU_PULSE_CYCLES 2
`endif

// [logic/dsu_tone_updater.sv]
// Periodic serial tone updater for four synthesizer chips
`include "dsu_regs.svh"
module dsu_tone_updater #(
	parameter int LINK_CLK_KHZ = `DSU_LINK_CLK_KHZ
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic toneValid,
	output logic toneReady,
	input wire dsu_pkg::dsu_tone_set_type toneData,
	output logic setupDone,
	output logic updateOverrun,
	input wire logic linkClk,
	output logic chipSclk,
	output logic chipCsN,
	output logic [`DSU_CHIPS-1:0] chipSdio,
	output logic [`DSU_CHIPS-1:0] chipIoUpdate,
	output logic [`DSU_CHIPS-1:0] chipIoReset,
	output logic chipMasterReset,
	input wire logic syncFromChip,
	output logic [`DSU_CHIPS-1:0] sequencer_align_sync
);
	import dsu_pkg::*;

	// ************************************************
	// Timing
	// ************************************************
	localparam int TICK_CYC = `DSU_UPDATE_NS * `DSU_REF_CLK_MHZ / 1000;
	localparam int HALF_RAW = (LINK_CLK_KHZ + 2 * `DSU_SER_RATE_KBPS - 1)
		/ (2 * `DSU_SER_RATE_KBPS);
	// Rounded up so the bit rate never exceeds the limit
	localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : HALF_RAW;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
	localparam logic [7:0] RST_LAST = 8'(`DSU_RESET_CYCLES - 1);
	localparam logic [7:0] PULSE_LAST = 8'(`DSU_PULSE_CYCLES - 1);

	function automatic dsu_word_type setupWord();
		logic [`DSU_SETUP_BITS-1:0] w;
		dsu_word_type r;
		w = {`DSU_CTRL_INSTR, `DSU_CTRL_LSB_FIRST};
		r = '0;
		// Chip still expects MSB first here
		for (int i = 0; i < `DSU_SETUP_BITS; i++) begin
			r[i] = w[`DSU_SETUP_BITS-1-i];
		end
		return r;
	endfunction

	// ************************************************
	// Reference clock domain
	// ************************************************
	dsu_ref_state_type r, next_r;
	dsu_link_state_type_s_type l, next_l;
	logic busy;
	logic tick;
	logic push;
	logic pop;

	always_comb begin
		next_r = r;
		busy = r.reqTog != r.ackSync2;
		tick = r.tick == TICK_LAST;
		push = toneValid && r.toneReady;
		pop = 1'b0;
		next_r.ackSync1 = l.ackTog;
		next_r.ackSync2 = r.ackSync1;
		next_r.setupSync1 = l.setupDone;
		next_r.setupSync2 = r.setupSync1;
		next_r.setupDone = r.setupSync2;
		next_r.overrun = 1'b0;
		next_r.tick = tick ? 8'h00 : r.tick + 8'h01;
		if (tick && r.setupDone) begin
			if (busy) begin
				next_r.overrun = 1'b1;
			end else begin
				// Without a new set the last one is resent
				if (r.count != 2'h0) begin
					pop = 1'b1;
					next_r.hold = r.fifo[r.rdPtr];
					next_r.rdPtr = ~r.rdPtr;
					next_r.haveTone = 1'b1;
				end
				if (r.count != 2'h0 || r.haveTone) begin
					next_r.reqTog = ~r.reqTog;
				end
			end
		end
		if (push) begin
			next_r.fifo[r.wrPtr] = toneData;
			next_r.wrPtr = ~r.wrPtr;
		end
		next_r.count = r.count + {1'b0, push} - {1'b0, pop};
		next_r.toneReady = next_r.count != 2'h2;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign toneReady = r.toneReady;
	assign setupDone = r.setupDone;
	assign updateOverrun = r.overrun;

	// ************************************************
	// Link clock domain
	// ************************************************
	logic lrst1;
	logic lrst2;

	// Reset release resynchronised to the link clock
	always_ff @(posedge linkClk) begin
		lrst1 <= rst_n;
		lrst2 <= lrst1;
	end

	always_comb begin
		next_l = l;
		next_l.reqSync1 = r.reqTog;
		next_l.reqSync2 = l.reqSync1;
		next_l.syncIn1 = syncFromChip;
		next_l.syncIn2 = l.syncIn1;
		// Only one chip's sync drives every chip, itself too
		next_l.alignOut = {`DSU_CHIPS{l.syncIn2}};
		case (l.state)
			L_RESET: begin
				next_l.masterReset = 1'b1;
				next_l.csN = 1'b1;
				next_l.setupDone = 1'b0;
				if (l.cnt == RST_LAST) begin
					next_l.masterReset = 1'b0;
					next_l.state = L_SETUP;
				end else begin
					next_l.cnt = l.cnt + 8'h01;
				end
			end
			L_SETUP: begin
				// Chip wakes up MSB first, so flip it once
				for (int i = 0; i < `DSU_CHIPS; i++) begin
					next_l.shift[i] = setupWord();
					next_l.sdio[i] = next_l.shift[i][0];
				end
				next_l.bitCnt = 6'(`DSU_SETUP_BITS);
				next_l.inSetup = 1'b1;
				next_l.halfCnt = HALF_LAST;
				next_l.sclk = 1'b0;
				next_l.csN = 1'b0;
				next_l.state = L_SHIFT;
			end
			L_IDLE: begin
				if (l.reqSync2 != l.reqSeen) begin
					next_l.reqSeen = l.reqSync2;
					// Hold is stable until the ack returns
					for (int i = 0; i < `DSU_CHIPS; i++) begin
						next_l.shift[i] = {r.hold[i].phase, r.hold[i].freq,
							`DSU_PROFILE_INSTR};
						next_l.sdio[i] = next_l.shift[i][0];
					end
					next_l.bitCnt = 6'(`DSU_WRITE_BITS);
					next_l.inSetup = 1'b0;
					next_l.halfCnt = HALF_LAST;
					next_l.sclk = 1'b0;
					next_l.csN = 1'b0;
					next_l.state = L_SHIFT;
				end
			end
			L_SHIFT: begin
				if (l.halfCnt != 8'h00) begin
					next_l.halfCnt = l.halfCnt - 8'h01;
				end else begin
					next_l.halfCnt = HALF_LAST;
					if (!l.sclk) begin
						next_l.sclk = 1'b1;
					end else begin
						next_l.sclk = 1'b0;
						if (l.bitCnt == 6'h01) begin
							next_l.csN = 1'b1;
							// One flop per chip, same edge for all
							next_l.ioUpdate = '1;
							next_l.cnt = 8'h00;
							next_l.state = L_UPDATE;
						end else begin
							next_l.bitCnt = l.bitCnt - 6'h01;
							for (int i = 0; i < `DSU_CHIPS; i++) begin
								next_l.shift[i] = l.shift[i] >> 1;
								next_l.sdio[i] = l.shift[i][1];
							end
						end
					end
				end
			end
			L_UPDATE: begin
				if (l.cnt == PULSE_LAST) begin
					next_l.ioUpdate = '0;
					next_l.ioReset = '1;
					next_l.cnt = 8'h00;
					next_l.state = L_ALIGN;
				end else begin
					next_l.cnt = l.cnt + 8'h01;
				end
			end
			L_ALIGN: begin
				if (l.cnt == PULSE_LAST) begin
					next_l.ioReset = '0;
					next_l.state = L_IDLE;
					if (l.inSetup) begin
						next_l.setupDone = 1'b1;
					end else begin
						// Cycle done well inside the period
						next_l.ackTog = ~l.ackTog;
					end
				end else begin
					next_l.cnt = l.cnt + 8'h01;
				end
			end
			default: begin
				next_l.state = L_RESET;
				next_l.cnt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge linkClk) begin
		if (!lrst2) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	assign chipSclk = l.sclk;
	assign chipCsN = l.csN;
	assign chipSdio = l.sdio;
	assign chipIoUpdate = l.ioUpdate;
	assign chipIoReset = l.ioReset;
	assign chipMasterReset = l.masterReset;
	assign sequencer_align_sync = l.alignOut;
endmodule

// [sim/dsu_chip_model.sv]
// Behavioural serial ports of the four synthesizer chips
module dsu_chip_model (
	input wire logic linkClk,
	input wire logic chipSclk,
	input wire logic chipCsN,
	input wire logic [3:0] chipSdio,
	input wire logic [3:0] chipIoUpdate,
	input wire logic [3:0] chipIoReset,
	input wire logic chipMasterReset,
	output logic syncFromChip = 0,
	output logic [3:0] lsbFirst = 0,
	output dsu_pkg::dsu_tone_set_type active = 0,
	output int nUpd = 0
);
	timeunit 1ns / 1ps;
	import dsu_pkg::*;
	// ****
	// Shift, apply and realign
	// ****
	logic [55:0] sh [4];
	logic lastSclk = 0;
	logic lastUpd = 0;
	int n = 0;
	always @(posedge linkClk) begin
		syncFromChip <= ~syncFromChip;
		lastSclk <= chipSclk;
		lastUpd <= chipIoUpdate[0];
		if (!chipCsN && chipSclk && !lastSclk) begin
			n <= n + 1;
			for (int k = 0; k < 4; k++)
				sh[k] <= {chipSdio[k], sh[k][55:1]};
		end
		for (int k = 0; k < 4; k++)
			if (chipIoUpdate[k] && !lastUpd) begin
				// Powers up MSB first; only the setup word flips it
				if (n == 40 && sh[k][55:16] == 40'h0000800000)
					lsbFirst[k] <= 1'b1;
				if (n == 56 && lsbFirst[k] && sh[k][7:0] == 8'h0e) begin
					active[k] <= {sh[k][39:8], sh[k][55:40]};
					if (k == 0)
						nUpd <= nUpd + 1;
				end
			end
		if (chipIoReset[0])
			n <= 0;
		if (chipMasterReset) begin
			n <= 0;
			lsbFirst <= '0;
		end
	end
endmodule

// [sim/dsu_tone_checker.sv]
// Port assertions of the tone updater
module dsu_tone_checker #(
	parameter int LINK_CLK_KHZ = 136000
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic updateOverrun,
	input wire logic linkClk,
	input wire logic chipSclk,
	input wire logic chipCsN,
	input wire logic [3:0] chipIoUpdate,
	input wire logic [3:0] chipIoReset,
	input wire logic chipMasterReset,
	input wire logic syncFromChip,
	input wire logic [3:0] sequencer_align_sync
);
	timeunit 1ns / 1ps;
	// ****
	// Bits counted per frame
	// ****
	logic [6:0] bits;
	logic lastSclk;
	always_ff @(posedge linkClk) begin
		lastSclk <= chipSclk;
		if (!rst_n || chipCsN)
			bits <= '0;
		else if (chipSclk && !lastSclk)
			bits <= bits + 7'd1;
	end
	a_apply_after_write: assert property (@(posedge linkClk) disable iff (!rst_n)
		$rose(chipCsN) && !chipMasterReset |-> chipIoUpdate == 4'hf) else $error("apply");
	a_apply_width: assert property (@(posedge linkClk) disable iff (!rst_n)
		$rose(chipIoUpdate[0]) |=> chipIoUpdate == 4'hf ##1 chipIoUpdate == 4'h0)
		else $error("apply width");
	a_realign_next: assert property (@(posedge linkClk) disable iff (!rst_n)
		$fell(chipIoUpdate[0]) |-> chipIoReset == 4'hf [*2] ##1 chipIoReset == 4'h0)
		else $error("realign");
	a_common_apply: assert property (@(posedge linkClk) disable iff (!rst_n)
		chipIoUpdate == 4'h0 || chipIoUpdate == 4'hf) else $error("split apply");
	a_frame_bits: assert property (@(posedge linkClk) disable iff (!rst_n)
		$rose(chipCsN) && !chipMasterReset |-> bits == 7'd56 || bits == 7'd40)
		else $error("frame length");
	a_bit_rate: assert property (@(posedge linkClk) disable iff (!rst_n)
		!chipCsN && $rose(chipSclk) |=> $fell(chipSclk)) else $error("bit rate");
	a_sync_fanout: assert property (@(posedge linkClk) disable iff (!rst_n)
		$past(rst_n, 8) |-> sequencer_align_sync == {4{$past(syncFromChip, 3)}})
		else $error("sync fanout");
	a_no_overrun: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!updateOverrun) else $error("overrun");
endmodule
bind dsu_tone_updater dsu_tone_checker #(.LINK_CLK_KHZ(LINK_CLK_KHZ)) dsu_tone_checker_i (.*);

// [sim/testbench.sv]
// Bench of the tone updater against the chip model
module testbench;
	timeunit 1ns / 1ps;
	import dsu_pkg::*;
	logic ref_clk = 0, linkClk = 0, rst_n = 0, toneValid = 0;
	logic toneReady, setupDone, updateOverrun, chipSclk, chipCsN, chipMasterReset, syncFromChip;
	logic [3:0] chipSdio, chipIoUpdate, chipIoReset, sequencer_align_sync, lsbFirst;
	dsu_tone_set_type toneData = '0, active, a, b, c;
	int nUpd, d, n_fail = 0, tests_run = 0;
	dsu_tone_updater #(.LINK_CLK_KHZ(136000)) dsu_tone_updater_i (.*);
	dsu_chip_model dsu_chip_model_i (.*);
	initial forever #10 ref_clk = ~ref_clk;
	initial #1.7 forever #3 linkClk = ~linkClk;
	initial begin
		#150us;
		n_fail++;
		results();
	end
	task automatic check(string s, logic [191:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic restart();
		@(posedge ref_clk);
		rst_n <= 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1;
		@(negedge ref_clk);
		check("setup in reset", setupDone, 0);
		for (int i = 0; i < 500 && setupDone !== 1; i++) @(negedge ref_clk);
		check("lsb first", lsbFirst, 4'hf);
	endtask
	task automatic push(dsu_tone_set_type s);
		@(posedge ref_clk);
		toneValid <= 1;
		toneData <= s;
		do @(negedge ref_clk); while (toneReady !== 1);
		@(posedge ref_clk);
		toneValid <= 0;
	endtask
	task automatic expect_set(dsu_tone_set_type s);
		for (int i = 0; i < 200 && active !== s; i++) @(negedge ref_clk);
		check("chip tones", active, s);
	endtask
	// ****
	// Buffered stream, order and repeat rate
	// ****
	task automatic t_stream();
		for (int k = 0; k < 4; k++) begin
			a[k] = {32'h01234567 * (k + 1), 16'h1200 + 16'(k)};
			b[k] = ~a[k];
			c[k] = {a[k][15:0], a[k][47:16]};
		end
		d = nUpd;
		repeat (150) @(negedge ref_clk);
		check("idle before set", nUpd - d, 0);
		push(a);
		push(b);
		repeat (2) @(negedge ref_clk);
		check("buffer full", toneReady, 0);
		push(c);
		expect_set(a);
		expect_set(b);
		expect_set(c);
		d = nUpd;
		repeat (500) @(negedge ref_clk);
		check("updates in 10us", nUpd - d inside {[9:11]}, 1);
		check("set resent", active, c);
	endtask
	initial begin
		restart();
		t_stream();
		restart();
		t_stream();
		results();
	end
endmodule
